// file: inc/epio_pkg.sv
// Package for the expansion port I/O block: offsets, modes, pin groups.
// Assumes a classic Wishbone slave with 32-bit data, one register per word.
package epio_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] EPIO_IDX_PORT_A_DATA = 8'h00;
  localparam logic [7:0] EPIO_IDX_PORT_B_DATA = 8'h01;
  localparam logic [7:0] EPIO_IDX_PORT_A_DIR = 8'h02;
  localparam logic [7:0] EPIO_IDX_PORT_B_DIR = 8'h03;
  localparam logic [7:0] EPIO_IDX_PORT_E_DATA = 8'h08;
  localparam logic [7:0] EPIO_IDX_PORT_E_DIR = 8'h09;
  localparam logic [7:0] EPIO_IDX_FUNC_SEL = 8'h0a;
  localparam logic [7:0] EPIO_IDX_CTRL = 8'h0b;
  // Registers below this index drop out in peripheral mode
  localparam logic [7:0] EPIO_IDX_EXP_LIMIT = 8'h10;
  localparam int EPIO_ADDR_LSB = 2;

  localparam logic [7:0] EPIO_DIR_RST = 8'h00;
  localparam logic [7:0] EPIO_DATA_RST = 8'h00;
  localparam logic [7:0] EPIO_FSEL_RST = 8'h00;
  // Interrupt pins can never be outputs
  localparam logic [7:0] EPIO_E_DIR_MASK = 8'hfc;
  // Pins with software pull-ups: enable, strobe, rw, two interrupts
  localparam logic [7:0] EPIO_E_PULL_MASK = 8'h8f;

  // Control register fields
  localparam int EPIO_CTRL_MODE_LSB = 0;
  localparam int EPIO_CTRL_EMU_BIT = 3;
  localparam int EPIO_CTRL_PULL_BIT = 4;

  typedef enum logic [2:0] {
    EPIO_MODE_SINGLE,
    EPIO_MODE_EXP_NARROW,
    EPIO_MODE_EXP_WIDE,
    EPIO_MODE_PERIPH
  } epio_mode_e;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } epio_pins_s;

  typedef struct packed {
    logic [7:0] a_data;
    logic [7:0] b_data;
    logic [7:0] a_dir;
    logic [7:0] b_dir;
    logic [7:0] e_data;
    logic [7:0] e_dir;
    logic [7:0] fsel;
    epio_mode_e mode;
    logic emu;
    logic pull_en;
    logic ack;
    logic [31:0] rdata;
    logic ext_req;
  } epio_state_s;

endpackage : epio_pkg

// file: src/epio_top.sv
// Expansion port I/O: ports A, B and E data/direction registers,
// on-chip map removal by mode, and bus lane and control pin muxing.
// Assumes a classic Wishbone master and an external bus engine
// supplying address, data and bus-control levels.
`timescale 1ns/10ps
`default_nettype none
module epio_top
  import epio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic ext_req_o,
  input wire logic [15:0] bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic bus_drive_i,
  input wire logic bus_addr_phase_i,
  output logic [15:0] bus_rdata_o,
  input wire logic [7:0] e_alt_out_i,
  input wire logic [7:0] high_bus_lane_pins_i,
  output logic [7:0] high_bus_lane_pins_o,
  output logic [7:0] high_bus_lane_pins_oe_o,
  input wire logic [7:0] low_bus_lane_pins_i,
  output logic [7:0] low_bus_lane_pins_o,
  output logic [7:0] low_bus_lane_pins_oe_o,
  input wire logic [7:0] port_e_pins_i,
  output logic [7:0] port_e_pins_o,
  output logic [7:0] port_e_pins_oe_o,
  output logic [7:0] port_e_pull_o
);

  epio_state_s st_ff;
  epio_state_s nxt_st;
  epio_pins_s pa;
  epio_pins_s pb;
  epio_pins_s pe;
  logic expanded;
  logic periph;
  logic wb_req;
  logic [7:0] idx;
  logic ab_mapped;
  logic e_mapped;
  logic [7:0] e_alt_sel;
  logic [7:0] e_dir_eff;
  logic [7:0] e_oe;
  logic [7:0] rd_byte;
  logic hit;

  // ---------------------------------------------------------------
  // Mode decode and map visibility
  // ---------------------------------------------------------------
  assign expanded = (st_ff.mode == EPIO_MODE_EXP_NARROW) || (st_ff.mode == EPIO_MODE_EXP_WIDE);
  assign periph = (st_ff.mode == EPIO_MODE_PERIPH);
  assign wb_req = wb_cyc_i && wb_stb_i && !st_ff.ack;
  assign idx = {2'b00, wb_adr_i[7:EPIO_ADDR_LSB]};
  assign ab_mapped = !(expanded || periph);
  assign e_mapped = !(periph || (expanded && st_ff.emu));

  // ---------------------------------------------------------------
  // Port E function select
  // ---------------------------------------------------------------
  // Alternates only apply outside single chip; interrupt pins never drive
  assign e_alt_sel = (st_ff.mode == EPIO_MODE_SINGLE) ? 8'h00 : (st_ff.fsel & EPIO_E_DIR_MASK);
  assign e_dir_eff = st_ff.e_dir & EPIO_E_DIR_MASK;
  for (genvar g = 0; g < 8; g++) begin : g_pe_pin
    // Alternate pins take their drive from the bus engine
    assign e_oe[g] = e_alt_sel[g] ? 1'b1 : e_dir_eff[g];
    assign pe.out[g] = e_alt_sel[g] ? e_alt_out_i[g] : st_ff.e_data[g];
  end
  assign pe.oe = e_oe;
  assign pe.pull = st_ff.pull_en ? (EPIO_E_PULL_MASK & ~e_oe) : 8'h00;

  // ---------------------------------------------------------------
  // Ports A and B lanes
  // ---------------------------------------------------------------
  always_comb begin
    pa.pull = 8'h00;
    pb.pull = 8'h00;
    if (ab_mapped) begin
      pa.out = st_ff.a_data;
      pa.oe = st_ff.a_dir;
      pb.out = st_ff.b_data;
      pb.oe = st_ff.b_dir;
    end else if (st_ff.mode == EPIO_MODE_EXP_NARROW) begin
      // Narrow: both data bytes share the high lane
      pa.out = bus_addr_phase_i ? bus_addr_i[15:8] : bus_wdata_i[15:8];
      pa.oe = (bus_addr_phase_i || bus_drive_i) ? 8'hff : 8'h00;
      pb.out = bus_addr_i[7:0];
      pb.oe = 8'hff;
    end else begin
      pa.out = bus_addr_phase_i ? bus_addr_i[15:8] : bus_wdata_i[15:8];
      pa.oe = (bus_addr_phase_i || bus_drive_i) ? 8'hff : 8'h00;
      pb.out = bus_addr_phase_i ? bus_addr_i[7:0] : bus_wdata_i[7:0];
      pb.oe = (bus_addr_phase_i || bus_drive_i) ? 8'hff : 8'h00;
    end
  end

  assign high_bus_lane_pins_o = pa.out;
  assign high_bus_lane_pins_oe_o = pa.oe;
  assign low_bus_lane_pins_o = pb.out;
  assign low_bus_lane_pins_oe_o = pb.oe;
  assign port_e_pins_o = pe.out;
  assign port_e_pins_oe_o = pe.oe;
  assign port_e_pull_o = pe.pull;
  assign bus_rdata_o = (st_ff.mode == EPIO_MODE_EXP_NARROW) ?
    {high_bus_lane_pins_i, high_bus_lane_pins_i} : {high_bus_lane_pins_i, low_bus_lane_pins_i};

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    hit = 1'b1;
    if (periph && (idx < EPIO_IDX_EXP_LIMIT)) begin
      hit = 1'b0;
    end else begin
      unique case (idx)
        EPIO_IDX_PORT_A_DATA: begin
          hit = ab_mapped;
          rd_byte = (st_ff.a_dir & st_ff.a_data) | (~st_ff.a_dir & high_bus_lane_pins_i);
        end
        EPIO_IDX_PORT_B_DATA: begin
          hit = ab_mapped;
          rd_byte = (st_ff.b_dir & st_ff.b_data) | (~st_ff.b_dir & low_bus_lane_pins_i);
        end
        EPIO_IDX_PORT_A_DIR: begin
          hit = ab_mapped;
          rd_byte = st_ff.a_dir;
        end
        EPIO_IDX_PORT_B_DIR: begin
          hit = ab_mapped;
          rd_byte = st_ff.b_dir;
        end
        EPIO_IDX_PORT_E_DATA: begin
          hit = e_mapped;
          // Undriven pins, interrupt pins included, read their level
          rd_byte = (e_oe & pe.out) | (~e_oe & port_e_pins_i);
        end
        EPIO_IDX_PORT_E_DIR: begin
          hit = e_mapped;
          rd_byte = e_dir_eff;
        end
        EPIO_IDX_FUNC_SEL: rd_byte = st_ff.fsel;
        EPIO_IDX_CTRL: rd_byte = {3'b000, st_ff.pull_en, st_ff.emu, st_ff.mode};
        default: hit = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State update
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.ext_req = 1'b0;
    if (wb_req) begin
      nxt_st.ack = 1'b1;
      // Removed registers answer but flag an external cycle
      nxt_st.ext_req = !hit;
      nxt_st.rdata = hit ? {24'h000000, rd_byte} : 32'h00000000;
      if (wb_we_i && hit && wb_sel_i[0]) begin
        unique case (idx)
          EPIO_IDX_PORT_A_DATA: nxt_st.a_data = wb_dat_i[7:0];
          EPIO_IDX_PORT_B_DATA: nxt_st.b_data = wb_dat_i[7:0];
          EPIO_IDX_PORT_A_DIR: nxt_st.a_dir = wb_dat_i[7:0];
          EPIO_IDX_PORT_B_DIR: nxt_st.b_dir = wb_dat_i[7:0];
          EPIO_IDX_PORT_E_DATA: nxt_st.e_data = wb_dat_i[7:0];
          EPIO_IDX_PORT_E_DIR: nxt_st.e_dir = wb_dat_i[7:0] & EPIO_E_DIR_MASK;
          EPIO_IDX_FUNC_SEL: nxt_st.fsel = wb_dat_i[7:0];
          EPIO_IDX_CTRL: begin
            nxt_st.mode = epio_mode_e'(wb_dat_i[EPIO_CTRL_MODE_LSB +: 3] & 3'h3);
            nxt_st.emu = wb_dat_i[EPIO_CTRL_EMU_BIT];
            nxt_st.pull_en = wb_dat_i[EPIO_CTRL_PULL_BIT];
          end
          default: nxt_st.ack = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '{a_data: EPIO_DATA_RST,
                 b_data: EPIO_DATA_RST,
                 a_dir: EPIO_DIR_RST,
                 b_dir: EPIO_DIR_RST,
                 e_data: EPIO_DATA_RST,
                 e_dir: EPIO_DIR_RST,
                 fsel: EPIO_FSEL_RST,
                 mode: EPIO_MODE_SINGLE,
                 emu: 1'b0,
                 pull_en: 1'b0,
                 ack: 1'b0,
                 rdata: 32'h00000000,
                 ext_req: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdata;
  assign ext_req_o = st_ff.ext_req;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  periph_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && periph && idx < EPIO_IDX_EXP_LIMIT |=> ext_req_o && wb_ack_o)
    else $error("peripheral mode register not removed");
  ab_removed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && expanded && idx == EPIO_IDX_PORT_A_DIR |=> ext_req_o && wb_dat_o == 32'h0)
    else $error("port A direction visible while expanded");
  e_emu_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && expanded && st_ff.emu && idx == EPIO_IDX_PORT_E_DATA |=> ext_req_o)
    else $error("port E data visible under emulation");
  gpio_a_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ab_mapped |-> high_bus_lane_pins_oe_o == st_ff.a_dir && high_bus_lane_pins_o == st_ff.a_data)
    else $error("port A not following its registers");
  narrow_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.mode == EPIO_MODE_EXP_NARROW |-> low_bus_lane_pins_o == bus_addr_i[7:0])
    else $error("low lane carries data in narrow mode");
  irq_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
    port_e_pins_oe_o[1:0] == 2'b00)
    else $error("interrupt pin driven");
  dir_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && wb_we_i && wb_sel_i[0] && ab_mapped && idx == EPIO_IDX_PORT_B_DIR
    |=> ##1 low_bus_lane_pins_oe_o == $past(wb_dat_i[7:0], 2))
    else $error("direction write not applied");
  pull_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (port_e_pull_o & port_e_pins_oe_o) == 8'h00 && (st_ff.pull_en || port_e_pull_o == 8'h00))
    else $error("pull-up on output pin");
  ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req
    |=> wb_ack_o)
    else $error("request not acknowledged");
  ext_with_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_req_o
    |-> wb_ack_o)
    else $error("external flag without ack");
  upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o
    |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  ctrl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && !wb_we_i && !periph && idx == EPIO_IDX_CTRL
    |=> wb_dat_o[7:0] == {3'b000, $past(st_ff.pull_en), $past(st_ff.emu), $past(st_ff.mode)})
    else $error("control readback wrong");

  // ---------------------------------------------------------------
  // Assertions: map removal and readback
  // ---------------------------------------------------------------
  // Removed registers must keep their value, or a later remap shows junk
  periph_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && wb_we_i && periph && idx == EPIO_IDX_CTRL
    |=> st_ff.mode == EPIO_MODE_PERIPH)
    else $error("peripheral mode left by write");
  ab_nowrite_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && wb_we_i && !ab_mapped && idx == EPIO_IDX_PORT_A_DATA
    |=> st_ff.a_data == $past(st_ff.a_data))
    else $error("removed port A data written");
  e_data_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && periph && idx == EPIO_IDX_PORT_E_DATA
    |=> ext_req_o)
    else $error("port E data visible in peripheral mode");
  e_dir_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && !e_mapped && idx == EPIO_IDX_PORT_E_DIR
    |=> ext_req_o)
    else $error("port E direction not removed");
  e_dir_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && !wb_we_i && e_mapped && idx == EPIO_IDX_PORT_E_DIR
    |=> wb_dat_o[1:0] == 2'b00 && !ext_req_o)
    else $error("interrupt direction bits read nonzero");
  e_dir_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> st_ff.e_dir[1:0] == 2'b00)
    else $error("interrupt direction bits stored");
  irq_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && !wb_we_i && e_mapped && idx == EPIO_IDX_PORT_E_DATA
    |=> wb_dat_o[1:0] == $past(port_e_pins_i[1:0]))
    else $error("interrupt pin level not read");
  a_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && !wb_we_i && ab_mapped && idx == EPIO_IDX_PORT_A_DATA
    |=> wb_dat_o[7:0] == (($past(st_ff.a_dir) & $past(st_ff.a_data)) |
                          (~$past(st_ff.a_dir) & $past(high_bus_lane_pins_i))))
    else $error("port A read mixes latch and pin wrongly");
  b_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && !wb_we_i && ab_mapped && idx == EPIO_IDX_PORT_B_DATA
    |=> wb_dat_o[7:0] == (($past(st_ff.b_dir) & $past(st_ff.b_data)) |
                          (~$past(st_ff.b_dir) & $past(low_bus_lane_pins_i))))
    else $error("port B read mixes latch and pin wrongly");

  // ---------------------------------------------------------------
  // Assertions: lanes and pins
  // ---------------------------------------------------------------
  wide_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.mode == EPIO_MODE_EXP_WIDE && bus_addr_phase_i
    |-> high_bus_lane_pins_o == bus_addr_i[15:8] && low_bus_lane_pins_o == bus_addr_i[7:0])
    else $error("address phase not on lanes");
  narrow_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.mode == EPIO_MODE_EXP_NARROW && !bus_addr_phase_i
    |-> high_bus_lane_pins_o == bus_wdata_i[15:8])
    else $error("narrow data not on high lane");
  wide_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.mode == EPIO_MODE_EXP_WIDE && !bus_addr_phase_i
    |-> low_bus_lane_pins_o == bus_wdata_i[7:0])
    else $error("wide data not on low lane");
  narrow_oe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.mode == EPIO_MODE_EXP_NARROW
    |-> low_bus_lane_pins_oe_o == 8'hff)
    else $error("narrow low lane released");
  gpio_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ab_mapped
    |-> low_bus_lane_pins_oe_o == st_ff.b_dir && low_bus_lane_pins_o == st_ff.b_data)
    else $error("port B not following its registers");
  dir_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i)
    |-> high_bus_lane_pins_oe_o == 8'h00 && low_bus_lane_pins_oe_o == 8'h00 && port_e_pins_oe_o == 8'h00)
    else $error("pin driven after reset");
  single_e_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.mode == EPIO_MODE_SINGLE
    |-> port_e_pins_oe_o == (st_ff.e_dir & EPIO_E_DIR_MASK))
    else $error("port E alternate active in single chip");
  alt_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> (port_e_pins_o & e_alt_sel) == (e_alt_out_i & e_alt_sel))
    else $error("alternate pin level not from bus engine");
  alt_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> (port_e_pins_oe_o & e_alt_sel) == e_alt_sel)
    else $error("alternate pin follows direction bit");
  gpio_e_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> (port_e_pins_oe_o & ~e_alt_sel) == (st_ff.e_dir & EPIO_E_DIR_MASK & ~e_alt_sel))
    else $error("port E GPIO direction wrong");
  pull_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |-> (port_e_pull_o & ~EPIO_E_PULL_MASK) == 8'h00)
    else $error("pull-up on pin without one");
  pull_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.pull_en
    |-> port_e_pull_o == (EPIO_E_PULL_MASK & ~port_e_pins_oe_o))
    else $error("pull-up missing on input pin");
  ext_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) ext_req_o);
  wr_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) wb_req && wb_we_i && hit);
  alt_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) e_alt_sel != 8'h00);
  narrow_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) st_ff.mode == EPIO_MODE_EXP_NARROW);

endmodule : epio_top
`default_nettype wire

// file: test/epio_ext_unit.sv
// Far-side model: external port replacement unit and pin loads on ports A, B and E.
// Assumes the bench supplies the level that the unit drives on pins the device releases.
`timescale 1ns/10ps
`default_nettype none
module epio_ext_unit (
  input wire logic [7:0] drv_i,
  input wire logic [7:0] a_o_i,
  input wire logic [7:0] a_oe_i,
  input wire logic [7:0] b_o_i,
  input wire logic [7:0] b_oe_i,
  input wire logic [7:0] e_o_i,
  input wire logic [7:0] e_oe_i,
  output logic [7:0] a_pin_o,
  output logic [7:0] b_pin_o,
  output logic [7:0] e_pin_o
);
  // ---------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------
  // Rebuilt ports drive only released pins; lane B sees the inverse so lanes differ
  assign a_pin_o = (a_oe_i & a_o_i) | (~a_oe_i & drv_i);
  assign b_pin_o = (b_oe_i & b_o_i) | (~b_oe_i & ~drv_i);
  assign e_pin_o = (e_oe_i & e_o_i) | (~e_oe_i & drv_i);
endmodule : epio_ext_unit
`default_nettype wire

// file: test/epio_top_tb.sv
// Self-checking bench for the expansion port block over classic Wishbone.
// Assumes epio_pkg and the far-side model epio_ext_unit are compiled first.
`timescale 1ns/10ps
`default_nettype none
module epio_top_tb
  import epio_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ext, drive = 1'b0, aph = 1'b0;
  logic [7:0] adr = 8'h00, drv = 8'h3e, alt = 8'h9a;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [15:0] brd;
  logic [7:0] ai, ao, aoe, bi, bo, boe, ei, eo, eoe, epull;
  int mismatches = 0, num_checks = 0, cycles = 0;

  always #4 clk_i = ~clk_i;

  epio_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ext_req_o(ext), .bus_addr_i(16'h1234), .bus_wdata_i(16'habcd), .bus_drive_i(drive),
    .bus_addr_phase_i(aph), .bus_rdata_o(brd), .e_alt_out_i(alt),
    .high_bus_lane_pins_i(ai), .high_bus_lane_pins_o(ao), .high_bus_lane_pins_oe_o(aoe),
    .low_bus_lane_pins_i(bi), .low_bus_lane_pins_o(bo), .low_bus_lane_pins_oe_o(boe),
    .port_e_pins_i(ei), .port_e_pins_o(eo), .port_e_pins_oe_o(eoe), .port_e_pull_o(epull));

  epio_ext_unit ext_unit (.drv_i(drv), .a_o_i(ao), .a_oe_i(aoe), .b_o_i(bo), .b_oe_i(boe),
    .e_o_i(eo), .e_oe_i(eoe), .a_pin_o(ai), .b_pin_o(bi), .e_pin_o(ei));

  // ---------------------------------------------------------------
  // Checks and bus cycles
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t value mismatch: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read data is compared on reads only; the external flag on every access
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [31:0] exp, input logic x);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx[5:0], 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    chk({31'h0, ack}, 32'h1);
    chk({31'h0, ext}, {31'h0, x});
    if (!w) chk(rdat, exp);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : acc

  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // Whole sequence takes between one and two hundred cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, EPIO_IDX_PORT_A_DIR, 0, 0, 0);
    acc(0, EPIO_IDX_PORT_B_DIR, 0, 0, 0);
    acc(0, EPIO_IDX_PORT_E_DIR, 0, 0, 0);
    @(negedge clk_i);
    chk({aoe, boe, eoe}, 0);
    acc(1, EPIO_IDX_PORT_A_DIR, 8'hf0, 0, 0);
    acc(1, EPIO_IDX_PORT_A_DATA, 8'ha5, 0, 0);
    acc(1, EPIO_IDX_PORT_B_DIR, 8'h0f, 0, 0);
    acc(1, EPIO_IDX_PORT_B_DATA, 8'h5a, 0, 0);
    @(negedge clk_i);
    chk({aoe, ao & aoe, boe, bo & boe}, 32'hf0a0_0f0a);
    acc(0, EPIO_IDX_PORT_A_DATA, 0, 32'hae, 0);
    acc(0, EPIO_IDX_PORT_B_DATA, 0, 32'hca, 0);
    acc(1, EPIO_IDX_PORT_E_DIR, 8'hff, 0, 0);
    acc(0, EPIO_IDX_PORT_E_DIR, 0, 32'hfc, 0);
    acc(1, EPIO_IDX_PORT_E_DATA, 8'h55, 0, 0);
    acc(0, EPIO_IDX_PORT_E_DATA, 0, 32'h56, 0);
    chk({24'h0, eoe}, 32'hfc);
    acc(1, EPIO_IDX_CTRL, 8'h10, 0, 0);
    @(negedge clk_i);
    chk({24'h0, epull}, 32'h03);
    acc(1, EPIO_IDX_PORT_E_DIR, 8'h00, 0, 0);
    @(negedge clk_i);
    chk({24'h0, epull}, 32'h8f);
    acc(1, EPIO_IDX_PORT_E_DIR, 8'hfc, 0, 0);
    acc(0, 8'h05, 0, 0, 1);
    // Expanded wide: port A/B registers go external, writes are dropped
    acc(1, EPIO_IDX_CTRL, 8'h02, 0, 0);
    for (int i = 0; i < 4; i++) acc(0, 8'(i), 0, 0, 1);
    acc(1, EPIO_IDX_PORT_A_DATA, 8'h00, 0, 1);
    acc(0, EPIO_IDX_PORT_E_DATA, 0, 32'h56, 0);
    acc(1, EPIO_IDX_FUNC_SEL, 8'hf0, 0, 0);
    @(negedge clk_i);
    chk({24'h0, eo & 8'hfc}, 32'h94);
    @(posedge clk_i);
    aph <= 1'b1;
    @(negedge clk_i);
    chk({ao, bo}, 32'h1234);
    @(posedge clk_i);
    aph <= 1'b0;
    drive <= 1'b1;
    @(negedge clk_i);
    chk({ao, bo}, 32'habcd);
    @(posedge clk_i);
    drive <= 1'b0;
    @(negedge clk_i);
    chk(brd, {drv, ~drv});
    acc(1, EPIO_IDX_CTRL, 8'h01, 0, 0);
    @(negedge clk_i);
    chk(brd, {drv, drv});
    acc(1, EPIO_IDX_CTRL, 8'h0a, 0, 0);
    acc(0, EPIO_IDX_PORT_E_DATA, 0, 0, 1);
    acc(0, EPIO_IDX_PORT_E_DIR, 0, 0, 1);
    acc(1, EPIO_IDX_CTRL, 8'h03, 0, 0);
    for (int i = 0; i < 16; i++) acc(0, 8'(i), 0, 0, 1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    acc(0, EPIO_IDX_PORT_A_DATA, 0, {24'h0, drv}, 0);
    conclude();
  end
endmodule : epio_top_tb
`default_nettype wire
